/* File: ssdes_top.sv */
// Spread-spectrum 21-bit deserializer core
//
// What this block does
// - Three serial lanes become one 21-bit parallel output word.
// - Forwarded link clock alone times deserialization; no recovery from data lanes.
// - Output clock and data spread by plus/minus two, four percent, or none.
// - Modulation runs 32 kHz at 33 MHz link, scaling with link rate.
// - Spreading works in both balanced and unbalanced coding.
// - Vertical sync bit 13, horizontal bit 6 clear the FIFO each frame.
// - The FIFO clear happens in vertical blanking, losing no picture data.
// - Balanced or unbalanced coding selectable; far end must match.
// - Output data stable for capture on falling edge of output clock.
// - Power-down low releases all data and clock outputs to high impedance.
// - Unbalanced coding: idle serial inputs give defined all-zero output.
`timescale 1ns/10ps
module ssdes_top #(
    parameter int DEPTH = ssdes_pkg::FIFO_DEPTH
) (
    input  wire logic                         clk,
    input  wire logic                         reset,
    input  wire logic                         link_clk,
    input  wire logic [ssdes_pkg::LANES-1:0]  lane_in,
    input  wire logic                         balance_en,
    input  wire logic [1:0]                   spread_sel,
    input  wire logic                         power_down_n,
    input  wire logic                         rx_ready,
    output logic [ssdes_pkg::WORD_W-1:0]      parallel_out_bit,
    output logic [ssdes_pkg::WORD_W-1:0]      parallel_out_bit_oe,
    output logic                              out_clk,
    output logic                              out_clk_oe
);

    localparam int AW = $clog2(DEPTH);
    localparam int WW = ssdes_pkg::WORD_W;
    localparam logic [AW:0] HALF_FILL = (AW+1)'(DEPTH / 2);
    localparam logic [AW:0] FULL_XOR  = {1'b1, {AW{1'b0}}};

    generate
        if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("DEPTH must be a power of two, at least 4");
        end
    endgenerate

    typedef struct packed {
        logic [ssdes_pkg::SYNC_W-1:0]                    s1;
        logic [ssdes_pkg::SYNC_W-1:0]                    s2;
        logic                                            lclk_d;
        logic [3:0]                                      phase;
        logic [7:0]                                      pcount;
        logic [7:0]                                      period;
        logic [7:0]                                      idle;
        logic                                            lost;
        logic [ssdes_pkg::LANES-1:0][ssdes_pkg::SLOTS-1:0] shreg;
        logic [DEPTH-1:0][WW-1:0]                        mem;
        logic [AW:0]                                     wr;
        logic [AW:0]                                     rd;
        logic                                            hold;
        logic                                            vs_d;
        logic                                            hs_d;
        logic [10:0]                                     tri_pos;
        logic [15:0]                                     acc;
        logic                                            oclk;
        logic [WW-1:0]                                   data;
    } ssdes_st_t;

    ssdes_st_t r;
    ssdes_st_t n;

    logic                        rise;
    logic                        bal;
    logic [3:0]                  cur_slot;
    logic                        slot_on;
    logic                        word_done;
    logic [ssdes_pkg::SLOTS-1:0] sym;
    logic [WW-1:0]               word;
    logic                        full;
    logic                        fifo_valid;
    logic                        buf_in_ready;
    logic                        buf_out_valid;
    logic [WW-1:0]               buf_out_data;
    logic                        buf_out_ready;
    logic                        tick;
    logic [10:0]                 maxdev;
    logic [10:0]                 fold;
    logic signed [11:0]          centred;
    logic signed [23:0]          prod;
    logic signed [17:0]          len_s;
    logic [15:0]                 cur_len;
    logic [15:0]                 acc_add;
    ssdes_pkg::ssdes_spread_t    spread;

    assign full       = ((r.wr ^ r.rd) == FULL_XOR);
    assign fifo_valid = (r.wr != r.rd) && !r.hold;
    assign spread     = ssdes_pkg::ssdes_spread_t'(r.s2[ssdes_pkg::SY_SPR +: 2]);

    ////////////////////////////////////////////////////////////////////////////
    // Spread modulation: triangle over the link-word count
    always_comb begin
        unique case (spread)
            ssdes_pkg::SSDES_SPREAD_2: maxdev = {3'h0, r.period} + {5'h00, r.period[7:2]};
            ssdes_pkg::SSDES_SPREAD_4: maxdev = {2'h0, r.period, 1'b0} + {4'h0, r.period[7:1]};
            ssdes_pkg::SSDES_SPREAD_OFF,
            ssdes_pkg::SSDES_SPREAD_RSV: maxdev = 11'h000;
        endcase
        // Position counts link words, so the rate follows the link clock
        if (r.tri_pos < 11'(ssdes_pkg::MOD_HALF)) begin
            fold = r.tri_pos;
        end else begin
            fold = 11'(ssdes_pkg::MOD_WORDS - 1) - r.tri_pos;
        end
        centred = $signed({1'b0, fold}) - 12'(ssdes_pkg::MOD_QTR);
        prod    = centred * $signed({1'b0, maxdev});
        // Spread steps approximate 2 and 4 percent with shifts, no divider
        len_s   = $signed({4'h0, r.period, 6'h00}) + 18'(prod >>> 8);
        cur_len = len_s[15:0];
        acc_add = r.acc + ssdes_pkg::FRAC_ONE;
        tick    = (r.period != 8'h00) && (acc_add >= cur_len);
    end

    assign buf_out_ready = tick & rx_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n   = r;
        sym = '0;
        word = '0;
        n.s1 = {power_down_n, spread_sel, balance_en, lane_in, link_clk};
        n.s2 = r.s1;
        n.lclk_d = r.s2[ssdes_pkg::SY_LCLK];
        rise = r.s2[ssdes_pkg::SY_LCLK] & ~r.lclk_d;
        bal  = r.s2[ssdes_pkg::SY_BAL];

        // Link period measurement and loss watch
        if (rise) begin
            n.pcount = 8'h00;
            // First rise after reset or loss has no valid start point, so wait one period
            if (r.lost) begin
                n.period = 8'h00;
            end else begin
                n.period = (r.pcount == 8'hff) ? 8'hff : r.pcount + 8'h01;
            end
            n.idle   = 8'h00;
            n.lost   = 1'b0;
        end else begin
            if (r.pcount != 8'hff) begin
                n.pcount = r.pcount + 8'h01;
            end
            if (r.idle != ssdes_pkg::LOSS_CYCLES) begin
                n.idle = r.idle + 8'h01;
            end else begin
                n.lost = 1'b1;
            end
        end

        // Bit slots counted from the sampled link clock edge
        cur_slot = rise ? 4'h0 : r.phase;
        slot_on  = (cur_slot < 4'(ssdes_pkg::SLOTS));
        if (rise) begin
            n.phase = 4'h1;
        end else if (slot_on) begin
            n.phase = r.phase + 4'h1;
        end
        word_done = slot_on && (cur_slot == 4'(ssdes_pkg::SLOTS - 1));
        for (int k = 0; k < ssdes_pkg::LANES; k++) begin
            if (slot_on) begin
                n.shreg[k] = {r.s2[ssdes_pkg::SY_LANE + k], r.shreg[k][ssdes_pkg::SLOTS-1:1]};
            end
            sym = n.shreg[k];
            if (bal && sym[ssdes_pkg::FLAG_BIT]) begin
                word[k*ssdes_pkg::LANE_BITS +: ssdes_pkg::LANE_BITS] = ~sym[ssdes_pkg::LANE_BITS-1:0];
            end else begin
                word[k*ssdes_pkg::LANE_BITS +: ssdes_pkg::LANE_BITS] = sym[ssdes_pkg::LANE_BITS-1:0];
            end
        end

        // FIFO drain into the output buffer
        if (fifo_valid && buf_in_ready) begin
            n.rd = r.rd + (AW+1)'(1);
        end

        // FIFO fill and per-frame clear
        if (word_done) begin
            n.tri_pos = (r.tri_pos == 11'(ssdes_pkg::MOD_WORDS - 1)) ? 11'h000 : r.tri_pos + 11'h001;
            if (!full) begin
                n.mem[r.wr[AW-1:0]] = word;
                n.wr = r.wr + (AW+1)'(1);
            end
            n.vs_d = word[ssdes_pkg::VSYNC_BIT];
            n.hs_d = word[ssdes_pkg::HSYNC_BIT];
            // Vsync sits in vertical blanking, so dropping words here costs no picture
            if (word[ssdes_pkg::VSYNC_BIT] && !r.vs_d) begin
                n.rd   = n.wr - HALF_FILL;
                n.hold = 1'b1;
            end else if (r.hold && word[ssdes_pkg::HSYNC_BIT] && !r.hs_d) begin
                n.hold = 1'b0;
            end
        end

        // Output clock: high in first half of each spread period
        if (r.period == 8'h00) begin
            n.acc = 16'h0000;
        end else if (tick) begin
            n.acc = acc_add - cur_len;
        end else begin
            n.acc = acc_add;
        end
        n.oclk = (n.acc < {1'b0, cur_len[15:1]});

        // Data changes with the rising edge, so it is settled by the falling one
        if (r.lost && !bal) begin
            n.data = '0;
        end else if (tick && buf_out_valid && rx_ready) begin
            n.data = buf_out_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            r       <= '0;
            r.phase <= ssdes_pkg::PHASE_RST;
            r.lost  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer, absorbs receiver stalls
    ssdes_skid #(
        .W (WW)
    ) u_skid (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (fifo_valid),
        .in_ready  (buf_in_ready),
        .in_data   (r.mem[r.rd[AW-1:0]]),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    assign parallel_out_bit    = r.data;
    assign out_clk             = r.oclk;
    assign parallel_out_bit_oe = {WW{r.s2[ssdes_pkg::SY_PD]}};
    assign out_clk_oe          = r.s2[ssdes_pkg::SY_PD];

endmodule // ssdes_top

/* File: ssdes_pkg.sv */
// Shared constants and types for the spread-spectrum deserializer
package ssdes_pkg;

    // Word and lane layout
    localparam int WORD_W    = 21;
    localparam int LANES     = 3;
    localparam int LANE_BITS = 7;
    localparam int SLOTS     = 8;
    localparam int FLAG_BIT  = 7;
    localparam int VSYNC_BIT = 13;
    localparam int HSYNC_BIT = 6;

    // Spreading FIFO
    localparam int FIFO_DEPTH = 8;

    // Modulation timing, reference point in kHz
    localparam int LINK_REF_KHZ = 33000;
    localparam int MOD_REF_KHZ  = 32;
    localparam int MOD_WORDS    = LINK_REF_KHZ / MOD_REF_KHZ;
    localparam int MOD_HALF     = MOD_WORDS / 2;
    localparam int MOD_QTR      = MOD_HALF / 2;

    // Output period kept in 1/64 of a clock cycle
    localparam int FRAC_SH = 6;
    localparam logic [15:0] FRAC_ONE = 16'h0040;

    // Link-loss timeout, in clock cycles
    localparam logic [7:0] LOSS_CYCLES = 8'h40;

    // Synchroniser bundle field positions
    localparam int SY_LCLK = 0;
    localparam int SY_LANE = 1;
    localparam int SY_BAL  = 4;
    localparam int SY_SPR  = 5;
    localparam int SY_PD   = 7;
    localparam int SYNC_W  = 8;

    // Reset values
    localparam logic [3:0] PHASE_RST = 4'h8;

    typedef enum logic [1:0] {
        SSDES_SPREAD_OFF = 2'b00,
        SSDES_SPREAD_2   = 2'b01,
        SSDES_SPREAD_4   = 2'b10,
        SSDES_SPREAD_RSV = 2'b11
    } ssdes_spread_t;

endpackage

/* File: ssdes_skid.sv */
// Two-entry valid/ready buffer in the output data path
`timescale 1ns/10ps
module ssdes_skid #(
    parameter int W = 21
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic              wp;
        logic              rp;
        logic [1:0]        cnt;
    } ssdes_skid_st_t;

    ssdes_skid_st_t r;
    ssdes_skid_st_t n;
    logic           push;
    logic           pop;

    assign in_ready  = (r.cnt != 2'h2);
    assign out_valid = (r.cnt != 2'h0);
    assign out_data  = r.mem[r.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = in_data;
            n.wp        = ~r.wp;
        end
        if (pop) begin
            n.rp = ~r.rp;
        end
        n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule // ssdes_skid

/* File: ssdes_serializer.sv */
// Behavioural far-end serializer: link clock plus three lanes
`timescale 1ns/10ps
module ssdes_serializer (
    input  wire logic        clk,
    input  wire logic        en,
    input  wire logic        bal,
    input  wire logic [20:0] word,
    output logic             link_clk,
    output logic [2:0]       lane_in
);
    logic [2:0]  slot_r = 3'h0;
    logic [20:0] cur_r = 21'h000000;
    logic [20:0] word_q = 21'h000000;
    logic        en_q = 1'b0;
    logic        bal_q = 1'b0;
    logic [20:0] src;
    logic [2:0]  inv;
    initial begin
        link_clk = 1'b0;
        lane_in = 3'h0;
    end
    ////////////////////////////////////////////////////////////////
    // Controls taken on the rising edge, so falling-edge stimulus cannot race the lanes
    always @(posedge clk) begin
        en_q <= en;
        bal_q <= bal;
        word_q <= word;
    end
    assign src = (slot_r == 3'h0) ? word_q : cur_r;
    // Lanes heavy in ones go inverted, flag in slot 7
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            inv[k] = bal_q && ($countones(src[7*k +: 7]) > 3);
        end
    end
    always @(negedge clk) begin
        if (!en_q) begin
            link_clk <= 1'b0;
            lane_in <= ~lane_in;
            slot_r <= 3'h0;
        end else begin
            link_clk <= (slot_r < 3'h4);
            if (slot_r == 3'h0) begin
                cur_r <= word_q;
            end
            for (int k = 0; k < 3; k++) begin
                lane_in[k] <= (slot_r == 3'h7) ? inv[k] : src[7*k + int'(slot_r)] ^ inv[k];
            end
            slot_r <= slot_r + 3'h1;
        end
    end
endmodule // ssdes_serializer

/* File: ssdes_top_monitor.sv */
// Concurrent checks on the deserializer's ports
`timescale 1ns/10ps
module ssdes_top_monitor #(
    parameter int DEPTH = 8
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        link_clk,
    input wire logic [2:0]  lane_in,
    input wire logic        balance_en,
    input wire logic [1:0]  spread_sel,
    input wire logic        power_down_n,
    input wire logic        rx_ready,
    input wire logic [20:0] parallel_out_bit,
    input wire logic [20:0] parallel_out_bit_oe,
    input wire logic        out_clk,
    input wire logic        out_clk_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [6:0] idle_r;
    ////////////////////////////////////////////////////////////////
    // Link-low run length; 72 leaves margin over sync plus 64
    always_ff @(posedge clk) begin
        if (reset || link_clk) begin
            idle_r <= 7'h00;
        end else if (idle_r != 7'h7f) begin
            idle_r <= idle_r + 7'h01;
        end
    end
    ////////////////////////////////////////////////////////////////
    oe_off_a: assert property (!power_down_n [*5] |-> parallel_out_bit_oe == 21'h0 && !out_clk_oe)
        else $error("outputs driven in power-down");
    oe_on_a: assert property (power_down_n [*5] |-> (&parallel_out_bit_oe) && out_clk_oe)
        else $error("outputs released while powered");
    oe_same_a: assert property (parallel_out_bit_oe == {21{out_clk_oe}})
        else $error("enables disagree");
    data_at_rise_a: assert property ($changed(parallel_out_bit) |-> $rose(out_clk) || parallel_out_bit == 21'h0)
        else $error("data moved away from clock rise");
    fall_stable_a: assert property ($fell(out_clk) |-> $stable(parallel_out_bit) || parallel_out_bit == 21'h0)
        else $error("data moved at strobe edge");
    stall_hold_a: assert property (!rx_ready |=> $stable(parallel_out_bit) || parallel_out_bit == 21'h0)
        else $error("data loaded during stall");
    clk_high_a: assert property ($rose(out_clk) |-> out_clk [*3])
        else $error("output clock high too short");
    fail_safe_a: assert property (idle_r >= 7'h48 && !balance_en && !$past(balance_en, 4)
        |-> parallel_out_bit == 21'h0)
        else $error("idle link gave nonzero data");
    reset_zero_a: assert property (disable iff (1'b0) reset |=> parallel_out_bit == 21'h0 && !out_clk
        && !out_clk_oe && parallel_out_bit_oe == 21'h0)
        else $error("outputs not cleared by reset");
    cover property ($rose(out_clk) && rx_ready);
    cover property (idle_r == 7'h48 && !balance_en);
    cover property ($fell(power_down_n));
endmodule // ssdes_top_monitor

bind ssdes_top ssdes_top_monitor #(.DEPTH(DEPTH)) i_ssdes_top_monitor (
    .clk(clk), .reset(reset), .link_clk(link_clk), .lane_in(lane_in), .balance_en(balance_en),
    .spread_sel(spread_sel), .power_down_n(power_down_n), .rx_ready(rx_ready),
    .parallel_out_bit(parallel_out_bit), .parallel_out_bit_oe(parallel_out_bit_oe),
    .out_clk(out_clk), .out_clk_oe(out_clk_oe)
);

/* File: tb_ssdes_top.sv */
// Self-checking bench for the spread-spectrum deserializer
`timescale 1ns/10ps
module tb_ssdes_top;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        en = 1'b0;
    logic        bal = 1'b0;
    logic [20:0] word = 21'h000000;
    logic [1:0]  spread_sel = 2'h0;
    logic        power_down_n = 1'b1;
    logic        rx_ready = 1'b1;
    logic        link_clk;
    logic [2:0]  lane_in;
    logic [20:0] parallel_out_bit;
    logic [20:0] parallel_out_bit_oe;
    logic        out_clk;
    logic        out_clk_oe;
    logic [20:0] cap = 21'h000000;
    logic        oc_q = 1'b0;
    int          errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          last = 0;
    int          mn = 99;
    int          mx = 0;
    int          ticks = 0;
    int          sp = 0;
    // Coding, spread select, then the word sent and expected back
    logic [23:0] rows [6] = '{24'h1f5a3c, 24'hafcf0f, 24'hdc1fff, 24'h60007f, 24'h555455, 24'h8a8040};
    ////////////////////////////////////////////////////////////////
    ssdes_top i_ssdes_top (
        .clk(clk), .reset(reset), .link_clk(link_clk), .lane_in(lane_in), .balance_en(bal),
        .spread_sel(spread_sel), .power_down_n(power_down_n), .rx_ready(rx_ready),
        .parallel_out_bit(parallel_out_bit), .parallel_out_bit_oe(parallel_out_bit_oe),
        .out_clk(out_clk), .out_clk_oe(out_clk_oe));
    ssdes_serializer i_ssdes_serializer (
        .clk(clk), .en(en), .bal(bal), .word(word), .link_clk(link_clk), .lane_in(lane_in));
    always #20 clk = ~clk;
    always @(negedge out_clk) cap = parallel_out_bit;
    // Output period tracking, plus the hang limit
    always @(negedge clk) begin
        cyc++;
        if (out_clk === 1'b1 && oc_q === 1'b0) begin
            ticks++;
            if (cyc - last < mn) mn = cyc - last;
            if (cyc - last > mx) mx = cyc - last;
            last = cyc;
        end
        oc_q = out_clk;
        if (cyc == 30000) begin
            errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic send(input int n);
        repeat (n * 8) @(negedge clk);
    endtask
    task automatic summarize();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        check(parallel_out_bit | parallel_out_bit_oe | 21'({out_clk, out_clk_oe}), 21'h0);
        reset = 1'b0;
        en = 1'b1;
        for (int i = 0; i < 6; i++) begin
            {bal, spread_sel, word} = rows[i];
            // A window shorter than the triangle may average up to the full spread
            sp = (spread_sel == 2'h1) ? 1 : (spread_sel == 2'h2) ? 2 : 0;
            send(32);
            mn = 99;
            mx = 0;
            ticks = 0;
            send(128);
            check(cap, rows[i][20:0]);
            check(21'(mn != 8 || mx != 8), 21'(rows[i][22:21] == 2'h1 || rows[i][22:21] == 2'h2));
            check(21'(ticks >= 126 - 2 * sp && ticks <= 130 + 2 * sp), 21'h1);
        end
        power_down_n = 1'b0;
        send(1);
        check(parallel_out_bit_oe | 21'(out_clk_oe), 21'h0);
        power_down_n = 1'b1;
        send(1);
        check(parallel_out_bit_oe, 21'h1fffff);
        rx_ready = 1'b0;
        word = 21'h0d4c21;
        send(24);
        check(cap, 21'h0a8040);
        rx_ready = 1'b1;
        send(24);
        check(cap, 21'h0d4c21);
        // Short vsync burst: a full FIFO would drop the hsync word
        word = 21'h0d6c21;
        send(3);
        check(cap, 21'h0d4c21);
        word = 21'h0d6c61;
        send(24);
        check(cap, 21'h0d6c61);
        en = 1'b0;
        send(12);
        check(parallel_out_bit, 21'h0d6c61);
        bal = 1'b0;
        en = 1'b1;
        send(24);
        en = 1'b0;
        send(12);
        check(parallel_out_bit, 21'h0);
        reset = 1'b1;
        send(1);
        check(parallel_out_bit | parallel_out_bit_oe, 21'h0);
        reset = 1'b0;
        word = 21'h1f5a3c;
        en = 1'b1;
        send(24);
        check(cap, 21'h1f5a3c);
        // One whole modulation period averages back to the link rate
        spread_sel = 2'h2;
        send(32);
        ticks = 0;
        send(ssdes_pkg::MOD_WORDS);
        check(21'(ticks >= ssdes_pkg::MOD_WORDS - 2 && ticks <= ssdes_pkg::MOD_WORDS + 4), 21'h1);
        summarize();
    end
endmodule // tb_ssdes_top
